// *** hdl/bcp_pkg.sv ***
// Package for the branch condition and prediction unit
package bcp_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam logic [31:0] INSN_STEP = 32'h0000_0004;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [31:0] WORD_MASK = 32'hffff_fffc;
  localparam logic [31:0] CNT_ONE = 32'h0000_0001;
  localparam int unsigned OPT_NO_CR = 4;
  localparam int unsigned OPT_CR_VAL = 3;
  localparam int unsigned OPT_NO_CNT = 2;
  localparam int unsigned OPT_CNT_ZERO = 1;
  localparam int unsigned OPT_REVERSE = 0;
  localparam int unsigned SIGN_BIT = 15;

  typedef enum logic [1:0] {
    BCP_REL = 2'b00,
    BCP_COND = 2'b01,
    BCP_TO_RET = 2'b10,
    BCP_TO_CNT = 2'b11
  } bcp_kind_t;

  typedef enum logic [1:0] {
    BCP_IDLE = 2'b00,
    BCP_WAIT = 2'b01
  } bcp_state_t;

  typedef struct packed {
    bcp_kind_t kind;
    logic [4:0] branch_options_field;
    logic [4:0] cond_select_index;
    logic [15:0] insn_lo;
    logic save_return_flag;
    logic [31:0] pc;
    logic [31:0] direct_target;
  } bcp_branch_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } bcp_redirect_t;
endpackage

// *** hdl/bcp_unit.sv ***
// Branch condition, static prediction and return-address logic
`timescale 1ns/1ps
module bcp_unit (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Branch issue from decode
  input wire logic br_valid,
  input wire bcp_pkg::bcp_branch_t br_info,
  // Resolution inputs, one cycle after issue
  input wire logic [31:0] condition_flags,
  // Special-register moves
  input wire logic mt_ret_we,
  input wire logic mt_cnt_we,
  input wire logic [31:0] general_reg_wdata,
  // Fetch control
  output bcp_pkg::bcp_redirect_t predict_redirect,
  output bcp_pkg::bcp_redirect_t recover_redirect,
  output logic flush_wrong_path,
  output logic branch_taken,
  output logic resolve_valid,
  // Register views
  output logic [31:0] return_address_reg,
  output logic [31:0] loop_counter
);
  bcp_pkg::bcp_state_t state;
  bcp_pkg::bcp_branch_t held;
  logic held_pred;
  bcp_pkg::bcp_state_t next_state;

  // All checks in this module share the core clock and reset
  default clocking cb_core @(posedge core_clk);
  endclocking
  default disable iff (srst);

  // Prediction from issue-time bits only
  wire logic [4:0] opt_i = br_info.branch_options_field;
  wire logic is_rel_i = (br_info.kind == bcp_pkg::BCP_REL);
  wire logic is_direct_i = is_rel_i || (br_info.kind == bcp_pkg::BCP_COND);
  wire logic sign_i = is_direct_i && br_info.insn_lo[bcp_pkg::SIGN_BIT];
  wire logic def_pred = (opt_i[bcp_pkg::OPT_NO_CR] && opt_i[bcp_pkg::OPT_NO_CNT]) || sign_i;
  wire logic rev_pred = def_pred ^ opt_i[bcp_pkg::OPT_REVERSE];
  wire logic pred_taken = is_rel_i ? 1'b1 : rev_pred;
  wire logic [31:0] target_i = (br_info.kind == bcp_pkg::BCP_TO_RET) ?
    (return_address_reg & bcp_pkg::WORD_MASK) :
    (br_info.kind == bcp_pkg::BCP_TO_CNT) ?
    (loop_counter & bcp_pkg::WORD_MASK) : br_info.direct_target;
  wire logic [31:0] seq_i = br_info.pc + bcp_pkg::INSN_STEP;
  wire logic [31:0] pred_addr = pred_taken ? target_i : seq_i;

  // Resolution on the held branch
  wire logic [4:0] opt = held.branch_options_field;
  wire logic is_rel = (held.kind == bcp_pkg::BCP_REL);
  wire logic cr_bit = condition_flags[5'd31 - held.cond_select_index];
  wire logic cr_ok = opt[bcp_pkg::OPT_NO_CR] ||
    (cr_bit == opt[bcp_pkg::OPT_CR_VAL]);
  wire logic [31:0] cnt_dec = loop_counter - bcp_pkg::CNT_ONE;
  wire logic cnt_zero = (cnt_dec == bcp_pkg::ZERO_WORD);
  wire logic cnt_ok = opt[bcp_pkg::OPT_NO_CNT] ||
    (cnt_zero == opt[bcp_pkg::OPT_CNT_ZERO]);
  wire logic taken = is_rel || (cr_ok && cnt_ok);
  wire logic do_dec = !is_rel && !opt[bcp_pkg::OPT_NO_CNT];
  wire logic resolving = (state == bcp_pkg::BCP_WAIT);
  wire logic mispredict = resolving && (taken != held_pred);
  wire logic [31:0] held_target = (held.kind == bcp_pkg::BCP_TO_RET) ?
    (return_address_reg & bcp_pkg::WORD_MASK) :
    (held.kind == bcp_pkg::BCP_TO_CNT) ?
    (loop_counter & bcp_pkg::WORD_MASK) : held.direct_target;
  wire logic [31:0] held_seq = held.pc + bcp_pkg::INSN_STEP;
  wire logic [31:0] fix_addr = taken ? held_target : held_seq;
  wire logic accept = br_valid && (state == bcp_pkg::BCP_IDLE);

  // Resolve cycle always returns to idle, so a request there is refused
  always_comb begin
    case (state)
      bcp_pkg::BCP_IDLE: begin
        next_state = accept ? bcp_pkg::BCP_WAIT : bcp_pkg::BCP_IDLE;
      end
      bcp_pkg::BCP_WAIT: begin
        next_state = bcp_pkg::BCP_IDLE;
      end
      default: begin
        next_state = bcp_pkg::BCP_IDLE;
      end
    endcase
  end
  wire logic [31:0] next_ret = (resolving && held.save_return_flag) ? held_seq :
    mt_ret_we ? general_reg_wdata : return_address_reg;
  wire logic [31:0] next_cnt = (resolving && do_dec) ? cnt_dec :
    mt_cnt_we ? general_reg_wdata : loop_counter;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= bcp_pkg::BCP_IDLE;
      held <= '0;
      held_pred <= 1'b0;
    end else begin
      state <= next_state;
      if (accept) begin
        held <= br_info;
        held_pred <= pred_taken;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      return_address_reg <= bcp_pkg::ZERO_WORD;
      loop_counter <= bcp_pkg::ZERO_WORD;
    end else begin
      return_address_reg <= next_ret;
      loop_counter <= next_cnt;
    end
  end

  // Prediction only steers fetch; state above depends on resolution alone
  always_ff @(posedge core_clk) begin
    if (srst) begin
      predict_redirect <= '0;
      recover_redirect <= '0;
      flush_wrong_path <= 1'b0;
      branch_taken <= 1'b0;
      resolve_valid <= 1'b0;
    end else begin
      predict_redirect.valid <= accept && pred_taken;
      predict_redirect.addr <= pred_addr;
      recover_redirect.valid <= mispredict;
      recover_redirect.addr <= fix_addr;
      flush_wrong_path <= mispredict;
      branch_taken <= resolving && taken;
      resolve_valid <= resolving;
    end
  end

  // Helpers for the checks below
  wire logic both_off_i = opt_i[bcp_pkg::OPT_NO_CR] && opt_i[bcp_pkg::OPT_NO_CNT];
  wire logic is_cond_i = (br_info.kind == bcp_pkg::BCP_COND);
  wire logic is_ind_i = !is_direct_i;
  wire logic rev_i = opt_i[bcp_pkg::OPT_REVERSE];
  wire logic cnt_one = (loop_counter == bcp_pkg::CNT_ONE);

  // Recovery after a wrong guess
  a_fix_on_miss: assert property (
    mispredict
    |=> recover_redirect.valid && flush_wrong_path)
    else $error("Mispredict not recovered");

  a_quiet_on_hit: assert property (
    resolving && !mispredict
    |=> !recover_redirect.valid && !flush_wrong_path)
    else $error("Recovery without mispredict");

  a_flush_pairs: assert property (
    flush_wrong_path
    |-> recover_redirect.valid)
    else $error("Flush without recovery address");

  // Static prediction
  a_pred_always: assert property (
    accept && both_off_i && !rev_i
    |=> predict_redirect.valid)
    else $error("Always form not predicted taken");

  a_pred_sign: assert property (
    accept && is_cond_i && br_info.insn_lo[bcp_pkg::SIGN_BIT] && !rev_i
    |=> predict_redirect.valid)
    else $error("Backward branch not predicted taken");

  a_pred_forward: assert property (
    accept && is_cond_i && !br_info.insn_lo[bcp_pkg::SIGN_BIT] && !both_off_i && !rev_i
    |=> !predict_redirect.valid)
    else $error("Forward branch predicted taken");

  a_indirect_sign: assert property (
    accept && is_ind_i && !both_off_i && !rev_i
    |=> !predict_redirect.valid)
    else $error("Indirect branch used a sign bit");

  a_indirect_always: assert property (
    accept && is_ind_i && both_off_i && !rev_i
    |=> predict_redirect.valid)
    else $error("Indirect always form not predicted");

  a_reverse_bit: assert property (
    accept && !is_rel_i && !sign_i && !opt_i[bcp_pkg::OPT_NO_CR] && rev_i
    |=> predict_redirect.valid)
    else $error("Reversal bit ignored");

  a_reverse_sign: assert property (
    accept && is_cond_i && br_info.insn_lo[bcp_pkg::SIGN_BIT] && rev_i
    |=> !predict_redirect.valid)
    else $error("Reversal of backward branch ignored");

  a_rel_predict: assert property (
    accept && is_rel_i
    |=> predict_redirect.valid && predict_redirect.addr == $past(br_info.direct_target))
    else $error("Unconditional branch not steered");

  a_pred_early: assert property (
    accept && pred_taken
    |=> predict_redirect.valid && !resolve_valid)
    else $error("Prediction not ahead of resolution");

  a_no_pred_idle: assert property (
    !accept
    |=> !predict_redirect.valid)
    else $error("Prediction without accepted branch");

  // Resolution
  a_uncond_taken: assert property (
    resolving && is_rel
    |=> branch_taken)
    else $error("Unconditional branch not taken");

  a_always_form: assert property (
    resolving && opt[bcp_pkg::OPT_NO_CR] && opt[bcp_pkg::OPT_NO_CNT]
    |=> branch_taken)
    else $error("Always form not taken");

  a_flag_miss: assert property (
    resolving && !is_rel && !opt[bcp_pkg::OPT_NO_CR] && (cr_bit != opt[bcp_pkg::OPT_CR_VAL])
    |=> !branch_taken)
    else $error("Taken despite failed flag test");

  a_flag_only: assert property (
    resolving && !is_rel && !opt[bcp_pkg::OPT_NO_CR] && opt[bcp_pkg::OPT_NO_CNT] &&
    (cr_bit == opt[bcp_pkg::OPT_CR_VAL]) |=> branch_taken)
    else $error("Flag-only branch not taken");

  a_cnt_fail: assert property (
    resolving && !is_rel && !opt[bcp_pkg::OPT_NO_CNT] && (cnt_one != opt[bcp_pkg::OPT_CNT_ZERO])
    |=> !branch_taken)
    else $error("Taken despite failed counter test");

  a_cnt_only: assert property (
    resolving && !is_rel && opt[bcp_pkg::OPT_NO_CR] && !opt[bcp_pkg::OPT_NO_CNT] &&
    (cnt_one == opt[bcp_pkg::OPT_CNT_ZERO]) |=> branch_taken)
    else $error("Counter-only branch not taken");

  a_resolve_pulse: assert property (
    resolve_valid
    |=> !resolve_valid)
    else $error("Resolve pulse too long");

  a_taken_resolved: assert property (
    branch_taken
    |-> resolve_valid)
    else $error("Taken without resolution");

  a_fall_through: assert property (
    mispredict && !taken
    |=> recover_redirect.addr == $past(held.pc) + bcp_pkg::INSN_STEP)
    else $error("Fall-through address wrong");

  // Return register and loop counter
  a_link_load: assert property (
    resolving && held.save_return_flag
    |=> return_address_reg == $past(held.pc) + bcp_pkg::INSN_STEP)
    else $error("Return address wrong");

  a_ret_hold: assert property (
    !mt_ret_we && !(resolving && held.save_return_flag)
    |=> $stable(return_address_reg))
    else $error("Return register changed unasked");

  a_ret_move: assert property (
    mt_ret_we && !(resolving && held.save_return_flag)
    |=> return_address_reg == $past(general_reg_wdata))
    else $error("Return register move lost");

  a_cnt_move: assert property (
    mt_cnt_we && !(resolving && do_dec)
    |=> loop_counter == $past(general_reg_wdata))
    else $error("Counter move lost");

  a_cnt_dec: assert property (
    resolving && do_dec
    |=> loop_counter == $past(loop_counter) - bcp_pkg::CNT_ONE)
    else $error("Counter not decremented");

  a_cnt_hold: assert property (
    resolving && !do_dec && !mt_cnt_we
    |=> $stable(loop_counter))
    else $error("Counter changed without decrement");

  a_ret_align: assert property (
    recover_redirect.valid && held.kind == bcp_pkg::BCP_TO_RET && branch_taken
    |-> recover_redirect.addr[1:0] == 2'b00)
    else $error("Return target unaligned");

  a_cnt_target: assert property (
    mispredict && taken && held.kind == bcp_pkg::BCP_TO_CNT
    |=> recover_redirect.addr == ($past(loop_counter) & bcp_pkg::WORD_MASK))
    else $error("Counter target wrong");

  // Main scenarios
  c_mispredict: cover property (
    mispredict);
  c_loop_exit: cover property (
    resolving && do_dec && cnt_zero);
  c_link_branch: cover property (
    resolving && held.save_return_flag);
  c_reversed: cover property (
    accept && rev_i);
  c_cnt_target: cover property (
    resolving && held.kind == bcp_pkg::BCP_TO_CNT && taken);
endmodule

// *** testbench/bcp_fetch_model.sv ***
// Fetch-side model that follows prediction and recovery redirects
`timescale 1ns/1ps
module bcp_fetch_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Redirects from the unit
  input wire bcp_pkg::bcp_redirect_t predict_redirect,
  input wire bcp_pkg::bcp_redirect_t recover_redirect,
  input wire logic flush_wrong_path,
  // Address being fetched
  output logic [31:0] fetch_pc
);
  always_ff @(posedge core_clk) begin
    if (srst) begin
      fetch_pc <= 32'h0000_0000;
    end else if (recover_redirect.valid && flush_wrong_path) begin
      fetch_pc <= recover_redirect.addr;
    end else if (predict_redirect.valid) begin
      fetch_pc <= predict_redirect.addr;
    end
  end
endmodule

// *** testbench/bcp_unit_tb_top.sv ***
// Self-checking bench for the branch condition and prediction unit
`timescale 1ns/1ps
module bcp_unit_tb_top;
  logic core_clk = 1'h0;
  logic srst = 1'h1;
  logic br_valid = 1'h0;
  bcp_pkg::bcp_branch_t br_info = '0;
  logic [31:0] condition_flags = 32'ha5c3_0f96;
  logic mt_ret_we = 1'h0;
  logic mt_cnt_we = 1'h0;
  logic [31:0] general_reg_wdata = 32'h0000_0000;
  bcp_pkg::bcp_redirect_t predict_redirect, recover_redirect;
  logic flush_wrong_path, branch_taken, resolve_valid;
  logic [31:0] return_address_reg, loop_counter, fetch_pc, m_ret, m_cnt;
  int n_fail = 0;
  int n_checks = 0;
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  bcp_unit u_dut (.core_clk(core_clk), .srst(srst), .br_valid(br_valid), .br_info(br_info),
    .condition_flags(condition_flags), .mt_ret_we(mt_ret_we), .mt_cnt_we(mt_cnt_we),
    .general_reg_wdata(general_reg_wdata), .predict_redirect(predict_redirect),
    .recover_redirect(recover_redirect), .flush_wrong_path(flush_wrong_path),
    .branch_taken(branch_taken), .resolve_valid(resolve_valid),
    .return_address_reg(return_address_reg), .loop_counter(loop_counter));
  bcp_fetch_model u_fetch (.core_clk(core_clk), .srst(srst), .predict_redirect(predict_redirect),
    .recover_redirect(recover_redirect), .flush_wrong_path(flush_wrong_path), .fetch_pc(fetch_pc));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic move(input logic to_cnt, input logic [31:0] val);
    @(posedge core_clk);
    mt_cnt_we <= to_cnt;
    mt_ret_we <= ~to_cnt;
    general_reg_wdata <= val;
    @(posedge core_clk);
    mt_cnt_we <= 1'h0;
    mt_ret_we <= 1'h0;
    #1;
    if (to_cnt) m_cnt = val;
    else m_ret = val;
    check(to_cnt ? loop_counter : return_address_reg, val);
  endtask
  // Second br_valid while hold is set lands in the refused cycle
  task automatic branch(input bcp_pkg::bcp_kind_t k, input logic [4:0] bo, input logic [15:0] lo,
      input logic lk, input logic [31:0] pc, input logic hold);
    logic [31:0] tgt, nc;
    logic pred, tk, cnt_ok, cr_ok;
    nc = bo[2] ? m_cnt : m_cnt - 32'h0000_0001;
    cnt_ok = bo[2] | (bo[1] ? (nc == 32'h0) : (nc != 32'h0));
    cr_ok = bo[4] | (condition_flags[5'h1f - pc[6:2]] == bo[3]);
    tk = (k == bcp_pkg::BCP_REL) | (cnt_ok & cr_ok);
    pred = (k == bcp_pkg::BCP_REL) |
      (((bo[4] & bo[2]) | (lo[15] & (k == bcp_pkg::BCP_COND))) ^ bo[0]);
    tgt = (k == bcp_pkg::BCP_TO_RET) ? (m_ret & bcp_pkg::WORD_MASK) :
      (k == bcp_pkg::BCP_TO_CNT) ? (m_cnt & bcp_pkg::WORD_MASK) : (32'h0000_8000 ^ pc);
    @(posedge core_clk);
    br_valid <= 1'h1;
    br_info <= '{k, bo, pc[6:2], lo, lk, pc, 32'h0000_8000 ^ pc};
    @(posedge core_clk);
    if (!hold) br_valid <= 1'h0;
    #1;
    check(predict_redirect.valid, pred);
    if (pred) check(predict_redirect.addr, tgt);
    @(posedge core_clk);
    br_valid <= 1'h0;
    #1;
    check(predict_redirect.valid, 32'h0000_0000);
    check(resolve_valid, 32'h0000_0001);
    check(branch_taken, tk);
    check(recover_redirect.valid, pred ^ tk);
    check(flush_wrong_path, pred ^ tk);
    if (pred ^ tk) check(recover_redirect.addr, tk ? tgt : pc + bcp_pkg::INSN_STEP);
    if (!bo[2] && k != bcp_pkg::BCP_REL) m_cnt = nc;
    if (lk) m_ret = pc + bcp_pkg::INSN_STEP;
    check(loop_counter, m_cnt);
    check(return_address_reg, m_ret);
    @(posedge core_clk);
    #1;
    check(resolve_valid, 32'h0000_0000);
    if (pred | tk) check(fetch_pc, tk ? tgt : pc + bcp_pkg::INSN_STEP);
  endtask
  initial begin
    logic [4:0] bo;
    bcp_pkg::bcp_kind_t k;
    m_ret = 32'h0000_0000;
    m_cnt = 32'h0000_0000;
    repeat (5) @(posedge core_clk);
    srst <= 1'h0;
    @(posedge core_clk);
    #1;
    check(return_address_reg, m_ret);
    check(loop_counter, m_cnt);
    $display("Test reset done");
    move(1'h0, 32'h1234_5677);
    move(1'h1, 32'h0000_0002);
    branch(bcp_pkg::BCP_REL, 5'h00, 16'h0000, 1'h1, 32'h0000_0040, 1'h1);
    $display("Test unconditional done");
    for (int i = 0; i < 96; i++) begin
      bo = i[4:0];
      k = bcp_pkg::bcp_kind_t'(2'(i / 32 + 1));
      if ((bo[2] & bo[1]) | (bo[4] & bo[3]) | (bo[4] & bo[2] & bo[0])) continue;
      if (k == bcp_pkg::BCP_TO_CNT && !bo[2]) continue;
      branch(k, bo, {i[0] ^ i[5], 15'h0000}, i[1], 32'(i * 4), 1'h0);
    end
    $display("Test option sweep done");
    results();
  end
endmodule
